//--- iass_pkg.sv
// Package: constants and types for interpolation accel control and single-step
package iass_pkg;

    // ****************************************
    // Host command codes
    // ****************************************
    localparam logic [7:0] IASS_CMD_MODE      = 8'h2a;
    localparam logic [7:0] IASS_CMD_INSTOP    = 8'h57;
    localparam logic [7:0] IASS_CMD_DECEL_ON  = 8'h6d;
    localparam logic [7:0] IASS_CMD_DECEL_OFF = 8'h6e;
    localparam logic [7:0] IASS_CMD_STEP      = 8'h6f;

    // ****************************************
    // Mode word fields and reset values
    // ****************************************
    localparam int IASS_MODE_EQOFF_BIT = 8;
    localparam int IASS_MODE_SSTEP_BIT = 9;
    localparam logic IASS_DECEL_EN_RST = 1'b0;
    localparam logic IASS_SSTEP_RST    = 1'b0;
    localparam logic IASS_EQOFF_RST    = 1'b0;

    // ****************************************
    // Timing and sizes
    // ****************************************
    localparam int IASS_CLK_NS       = 10;
    localparam int IASS_EXT_LAT_MIN  = 2;
    localparam int IASS_EXT_LAT_MAX  = 5;
    localparam int IASS_EXT_LOW_MIN  = 4;
    localparam int IASS_AXES         = 4;
    localparam int IASS_CNT_W        = 32;
    localparam int IASS_PER_W        = 24;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        IASS_KIND_LINEAR,
        IASS_KIND_CIRCULAR,
        IASS_KIND_BITPAT
    } iass_kind_t;

    typedef enum logic [1:0] {
        IASS_ST_IDLE,
        IASS_ST_WAIT,
        IASS_ST_HIGH
    } iass_state_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  code;
        logic [15:0] data;
    } iass_hcmd_t;

    typedef struct packed {
        logic scurve_enable;
        logic auto_decel_enable;
        logic decel_start;
    } iass_decel_t;

endpackage : iass_pkg

//--- iass_step_src.sv
// External step source model driving the active-low step input
`timescale 1ns/1ns

module iass_step_src #(
    parameter int LOW_CYCLES = 6
) (
    // Clock
    input  wire logic clk,
    // Request from the bench
    input  wire logic fire,
    // Step line
    output logic      ext_step_trigger_n
);
    int low_left = 0;

    initial ext_step_trigger_n = 1'b1;

    // Low phase kept well over four clocks so the synchroniser cannot miss it
    always @(posedge clk) begin
        if (fire) begin
            ext_step_trigger_n <= 1'b0;
            low_left           <= LOW_CYCLES;
        end else if (low_left > 1) begin
            low_left <= low_left - 1;
        end else begin
            low_left           <= 0;
            ext_step_trigger_n <= 1'b1;
        end
    end
endmodule : iass_step_src

//--- iass_top.sv
// Interpolation acceleration/deceleration control and single-step pulse output
`timescale 1ns/1ns

// Contract
// - 6Dh enables, 6Eh disables interpolation deceleration
// - Deceleration disabled after reset
// - Enabling command ignored while driving
// - Linear allows trapezoid, S-curve, auto or manual; code also blocks S-curve while single-step mode is set
// - No S-curve with short axis equalization
// - Circular, bit pattern: trapezoid, manual only
// - Continuous: trapezoid, manual only
// - Count main pulses from tagged segment start
// - One step per command or external trigger
// - High half period, low until next trigger
// - Mode bit D9 of 2Ah enables single-step
// - Interpolation command arms without pulses
// - Each 6Fh outputs next pulses on axes
// - Instant stop then step ends drive
// - Step commands after finish ignored
// - External step idles high, falling edge triggers
// - Pulse starts 2 to 5 clocks after fall
// - External lows after finish ignored
// - No debounce on external step input
module iass_top
    import iass_pkg::*;
#(
    parameter int AXES  = IASS_AXES,
    parameter int CNT_W = IASS_CNT_W,
    parameter int PER_W = IASS_PER_W
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                sys_rst,
    // Host commands
    input  wire iass_hcmd_t          host_cmd,
    input  wire logic                interp_write,
    input  wire iass_kind_t          interp_kind,
    input  wire logic                interp_continuous,
    input  wire logic                scurve_select,
    input  wire logic [CNT_W-1:0]    manual_decel_point,
    input  wire logic [PER_W-1:0]    main_pulse_period,
    // Interpolation engine
    input  wire logic                drive_busy,
    input  wire logic                seg_enter,
    input  wire logic                main_pulse,
    input  wire logic                auto_decel_req,
    input  wire logic                interp_done,
    input  wire logic [AXES-1:0]     step_axes,
    // External step input
    input  wire logic                ext_step_trigger_n,
    // Deceleration control
    output iass_decel_t              decel_ctl,
    output logic                     decel_enabled,
    // Single-step
    output logic                     sstep_mode,
    output logic                     step_req,
    output logic                     drive_stop,
    output logic [AXES-1:0]          axis_pulse
);

    // ****************************************
    // Command decode
    // ****************************************
    function automatic logic cmd_is(input iass_hcmd_t c, input logic [7:0] code);
        cmd_is = c.valid && (c.code == code);
    endfunction : cmd_is
    wire logic cmd_on   = cmd_is(host_cmd, IASS_CMD_DECEL_ON);
    wire logic cmd_off  = cmd_is(host_cmd, IASS_CMD_DECEL_OFF);
    wire logic cmd_mode = cmd_is(host_cmd, IASS_CMD_MODE);
    wire logic cmd_step = cmd_is(host_cmd, IASS_CMD_STEP);
    wire logic cmd_stop = cmd_is(host_cmd, IASS_CMD_INSTOP);

    // ****************************************
    // Mode and deceleration enable
    // ****************************************
    logic eq_off;
    logic next_decel_enabled;
    logic next_sstep_mode;
    logic next_eq_off;

    always_comb begin
        next_decel_enabled = decel_enabled;
        next_sstep_mode    = sstep_mode;
        next_eq_off        = eq_off;
        if (cmd_on && !drive_busy) begin
            next_decel_enabled = 1'b1;
        end else if (cmd_off) begin
            next_decel_enabled = 1'b0;
        end
        if (cmd_mode) begin
            next_sstep_mode = host_cmd.data[IASS_MODE_SSTEP_BIT];
            next_eq_off     = host_cmd.data[IASS_MODE_EQOFF_BIT];
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            decel_enabled <= IASS_DECEL_EN_RST;
            sstep_mode    <= IASS_SSTEP_RST;
            eq_off        <= IASS_EQOFF_RST;
        end else begin
            decel_enabled <= next_decel_enabled;
            sstep_mode    <= next_sstep_mode;
            eq_off        <= next_eq_off;
        end
    end

    // ****************************************
    // Profile permission
    // ****************************************
    logic linear_single;
    logic auto_ok;
    logic scurve_ok;
    assign linear_single = (interp_kind == IASS_KIND_LINEAR) && !interp_continuous;
    assign auto_ok       = linear_single && decel_enabled;
    assign scurve_ok     = linear_single && eq_off && !sstep_mode;

    // ****************************************
    // Segment tag and manual point counter
    // ****************************************
    // Enable sampled at segment write: a chain counts from the marked segment's entry until done
    logic             seg_tag;
    logic             cnt_on;
    logic [CNT_W-1:0] seg_cnt;
    logic             decel_start;
    logic             next_seg_tag;
    logic             next_cnt_on;
    logic [CNT_W-1:0] next_seg_cnt;
    logic             next_decel_start;

    always_comb begin
        next_seg_tag     = seg_tag;
        next_cnt_on      = cnt_on;
        next_seg_cnt     = seg_cnt;
        next_decel_start = decel_start;
        if (interp_write) begin
            next_seg_tag = decel_enabled;
        end
        if (seg_enter && seg_tag && !cnt_on) begin
            next_cnt_on  = 1'b1;
            next_seg_cnt = '0;
        end else if (cnt_on && main_pulse && !(&seg_cnt)) begin
            next_seg_cnt = seg_cnt + 1'b1;
        end
        if (cnt_on && (seg_cnt > manual_decel_point)) begin
            next_decel_start = 1'b1;
        end else if (auto_ok && auto_decel_req) begin
            next_decel_start = 1'b1;
        end
        // Deceleration carries across segments until the drive ends
        if (interp_done) begin
            next_cnt_on      = 1'b0;
            next_seg_tag     = 1'b0;
            next_decel_start = 1'b0;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            seg_tag     <= 1'b0;
            cnt_on      <= 1'b0;
            seg_cnt     <= '0;
            decel_start <= 1'b0;
        end else begin
            seg_tag     <= next_seg_tag;
            cnt_on      <= next_cnt_on;
            seg_cnt     <= next_seg_cnt;
            decel_start <= next_decel_start;
        end
    end

    assign decel_ctl.scurve_enable     = scurve_ok && scurve_select;
    assign decel_ctl.auto_decel_enable = auto_ok;
    assign decel_ctl.decel_start       = decel_start;

    // ****************************************
    // External step synchroniser
    // ****************************************
    // No filter: every clean low pulse gives exactly one falling-edge trigger
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_s1 <= 1'b1;
            ext_s2 <= 1'b1;
            ext_s3 <= 1'b1;
        end else begin
            ext_s1 <= ext_step_trigger_n;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    wire logic ext_fall = ext_s3 && !ext_s2;

    // ****************************************
    // Single-step sequencer
    // ****************************************
    iass_state_t      state;
    iass_state_t      next_state;
    logic [PER_W-1:0] hcnt;
    logic [PER_W-1:0] next_hcnt;
    logic [AXES-1:0]  next_axis_pulse;
    logic             abort;
    logic             next_abort;
    logic             next_drive_stop;
    logic             fin;
    logic             next_fin;
    logic [PER_W-1:0] half_per;

    wire logic trig = cmd_step || ext_fall;
    assign half_per = (main_pulse_period > 1) ? (main_pulse_period >> 1) : PER_W'(1);
    assign step_req = trig && (state == IASS_ST_WAIT) && !abort;

    always_comb begin
        next_state      = state;
        next_hcnt       = hcnt;
        next_axis_pulse = axis_pulse;
        next_abort      = abort;
        next_drive_stop = 1'b0;
        next_fin        = fin;
        if (cmd_stop && state != IASS_ST_IDLE) begin
            next_abort = 1'b1;
        end
        case (state)
            IASS_ST_IDLE: begin
                if (interp_write && sstep_mode) begin
                    next_state = IASS_ST_WAIT;
                    next_abort = 1'b0;
                end
            end
            IASS_ST_WAIT: begin
                if (interp_done) begin
                    next_state = IASS_ST_IDLE;
                end else if (trig && abort) begin
                    next_state      = IASS_ST_IDLE;
                    next_drive_stop = 1'b1;
                    next_abort      = 1'b0;
                end else if (step_req) begin
                    next_state      = IASS_ST_HIGH;
                    next_axis_pulse = step_axes;
                    next_hcnt       = half_per - 1'b1;
                end
            end
            IASS_ST_HIGH: begin
                next_fin = fin || interp_done;
                if (hcnt == '0) begin
                    next_state      = next_fin ? IASS_ST_IDLE : IASS_ST_WAIT;
                    next_axis_pulse = '0;
                    next_fin        = 1'b0;
                end else begin
                    next_hcnt = hcnt - 1'b1;
                end
            end
            default: begin
                next_state = IASS_ST_IDLE;
            end
        endcase
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state      <= IASS_ST_IDLE;
            hcnt       <= '0;
            axis_pulse <= '0;
            abort      <= 1'b0;
            drive_stop <= 1'b0;
            fin        <= 1'b0;
        end else begin
            state      <= next_state;
            hcnt       <= next_hcnt;
            axis_pulse <= next_axis_pulse;
            abort      <= next_abort;
            drive_stop <= next_drive_stop;
            fin        <= next_fin;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_decel_on;
        @(posedge clk) disable iff (sys_rst)
        (cmd_on && !drive_busy && !cmd_off) |=> decel_enabled;
    endproperty
    a_decel_on: assert property (p_decel_on) else $error("decel enable missed");
    property p_decel_off;
        @(posedge clk) disable iff (sys_rst)
        (cmd_off && !(cmd_on && !drive_busy)) |=> !decel_enabled;
    endproperty
    a_decel_off: assert property (p_decel_off) else $error("decel disable missed");
    property p_reset_off;
        @(posedge clk) $fell(sys_rst) |-> !decel_enabled;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("decel on after reset");
    property p_busy_ignore;
        @(posedge clk) disable iff (sys_rst)
        (cmd_on && drive_busy && !cmd_off) |=> $stable(decel_enabled);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("enable taken while busy");
    property p_no_scurve_eq;
        @(posedge clk) disable iff (sys_rst)
        !eq_off |-> !decel_ctl.scurve_enable;
    endproperty
    a_no_scurve_eq: assert property (p_no_scurve_eq) else $error("s-curve in equalize");
    property p_manual_only;
        @(posedge clk) disable iff (sys_rst)
        (interp_kind != IASS_KIND_LINEAR || interp_continuous)
            |-> !decel_ctl.scurve_enable && !decel_ctl.auto_decel_enable;
    endproperty
    a_manual_only: assert property (p_manual_only) else $error("auto or s-curve allowed");
    property p_low_hold;
        @(posedge clk) disable iff (sys_rst)
        (state == IASS_ST_WAIT && !step_req) |=> axis_pulse == '0;
    endproperty
    a_low_hold: assert property (p_low_hold) else $error("pulse without trigger");
    property p_ext_latency;
        @(posedge clk) disable iff (sys_rst)
        ($fell(ext_step_trigger_n) && state == IASS_ST_WAIT && !abort && !cmd_step)
            ##1 (state == IASS_ST_WAIT && !interp_done && !cmd_step)[*2]
            |-> ##[0:2] step_req;
    endproperty
    a_ext_latency: assert property (p_ext_latency) else $error("ext step late");
    property p_idle_ignore;
        @(posedge clk) disable iff (sys_rst)
        (state == IASS_ST_IDLE && trig) |=> axis_pulse == '0 && state != IASS_ST_HIGH;
    endproperty
    a_idle_ignore: assert property (p_idle_ignore) else $error("step after finish");
    property p_manual_hit;
        @(posedge clk) disable iff (sys_rst)
        $rose(decel_start) |-> $past(seg_cnt > manual_decel_point && cnt_on)
            || $past(auto_ok && auto_decel_req);
    endproperty
    a_manual_hit: assert property (p_manual_hit) else $error("decel without cause");

endmodule : iass_top

//--- iass_top_bench.sv
// Self-checking bench for interpolation accel control and single-step
`timescale 1ns/1ns

module iass_top_bench;
    import iass_pkg::*;

    typedef struct packed {
        logic       eq;
        iass_kind_t kind;
        logic       cont;
        logic       ssel;
        logic       sc;
        logic       ad;
    } iass_row_t;

    // ****************************************
    // Signals
    // ****************************************
    logic                  clk                = 1'b0;
    logic                  sys_rst            = 1'b1;
    iass_hcmd_t            host_cmd           = '0;
    logic                  interp_write       = 1'b0;
    iass_kind_t            interp_kind        = IASS_KIND_LINEAR;
    logic                  interp_continuous  = 1'b0;
    logic                  scurve_select      = 1'b0;
    logic [IASS_CNT_W-1:0] manual_decel_point = 32'h00000003;
    logic [IASS_PER_W-1:0] main_pulse_period  = 24'h000008;
    logic                  drive_busy         = 1'b0;
    logic                  seg_enter          = 1'b0;
    logic                  main_pulse         = 1'b0;
    logic                  auto_decel_req     = 1'b0;
    logic                  interp_done        = 1'b0;
    logic [IASS_AXES-1:0]  step_axes          = 4'ha;
    logic                  src_fire           = 1'b0;
    logic                  ext_step_trigger_n;
    iass_decel_t           decel_ctl;
    logic                  decel_enabled;
    logic                  sstep_mode;
    logic                  step_req;
    logic                  drive_stop;
    logic [IASS_AXES-1:0]  axis_pulse;
    logic [IASS_AXES-1:0]  seen_p;
    logic                  seen_s;
    int                    bad_count          = 0;
    int                    num_checks         = 0;
    int                    n;

    iass_row_t rows [6] = '{
        '{1'b1, IASS_KIND_LINEAR,   1'b0, 1'b1, 1'b1, 1'b1},
        '{1'b1, IASS_KIND_LINEAR,   1'b1, 1'b1, 1'b0, 1'b0},
        '{1'b1, IASS_KIND_CIRCULAR, 1'b0, 1'b1, 1'b0, 1'b0},
        '{1'b1, IASS_KIND_BITPAT,   1'b0, 1'b1, 1'b0, 1'b0},
        '{1'b1, IASS_KIND_LINEAR,   1'b0, 1'b0, 1'b0, 1'b1},
        '{1'b0, IASS_KIND_LINEAR,   1'b0, 1'b1, 1'b0, 1'b1}
    };

    iass_top u_dut (
        .clk(clk), .sys_rst(sys_rst), .host_cmd(host_cmd), .interp_write(interp_write),
        .interp_kind(interp_kind), .interp_continuous(interp_continuous),
        .scurve_select(scurve_select), .manual_decel_point(manual_decel_point),
        .main_pulse_period(main_pulse_period), .drive_busy(drive_busy),
        .seg_enter(seg_enter), .main_pulse(main_pulse), .auto_decel_req(auto_decel_req),
        .interp_done(interp_done), .step_axes(step_axes),
        .ext_step_trigger_n(ext_step_trigger_n), .decel_ctl(decel_ctl),
        .decel_enabled(decel_enabled), .sstep_mode(sstep_mode), .step_req(step_req),
        .drive_stop(drive_stop), .axis_pulse(axis_pulse)
    );

    iass_step_src u_src (.clk(clk), .fire(src_fire), .ext_step_trigger_n(ext_step_trigger_n));

    always #5 clk = ~clk;

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic cmd(input logic [7:0] code, input logic [15:0] data);
        @(posedge clk);
        host_cmd <= '{valid: 1'b1, code: code, data: data};
        @(posedge clk);
        host_cmd <= '0;
        #1;
    endtask : cmd

    // One-cycle strobe: 0 write, 1 segment entry, 2 main pulse, 3 done, 4 ext fire,
    // 5 automatic decel request
    task automatic strobe(input int which);
        @(posedge clk);
        case (which)
            0: interp_write <= 1'b1;
            1: seg_enter <= 1'b1;
            2: main_pulse <= 1'b1;
            3: interp_done <= 1'b1;
            4: src_fire <= 1'b1;
            default: auto_decel_req <= 1'b1;
        endcase
        @(posedge clk);
        {interp_write, seg_enter, main_pulse, interp_done, src_fire, auto_decel_req} <= '0;
        #1;
    endtask : strobe

    // Collects any pulse or stop seen over a number of cycles
    task automatic watch(input int cycles);
        seen_p = '0;
        seen_s = 1'b0;
        repeat (cycles) begin
            @(posedge clk);
            #1;
            seen_p = seen_p | axis_pulse;
            seen_s = seen_s | drive_stop;
        end
    endtask : watch

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #200000;
        bad_count++;
        end_of_test();
    end

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        check("decel_enabled reset", decel_enabled, IASS_DECEL_EN_RST);
        check("sstep_mode reset", sstep_mode, IASS_SSTEP_RST);
        cmd(IASS_CMD_DECEL_ON, 16'h0000);
        check("decel on", decel_enabled, 1'b1);
        cmd(IASS_CMD_DECEL_OFF, 16'h0000);
        check("decel off", decel_enabled, 1'b0);
        @(posedge clk);
        drive_busy <= 1'b1;
        cmd(IASS_CMD_DECEL_ON, 16'h0000);
        check("decel on while busy", decel_enabled, 1'b0);
        @(posedge clk);
        drive_busy <= 1'b0;
        cmd(IASS_CMD_DECEL_ON, 16'h0000);
        foreach (rows[i]) begin
            cmd(IASS_CMD_MODE, {7'h00, rows[i].eq, 8'h00});
            @(posedge clk);
            interp_kind       <= rows[i].kind;
            interp_continuous <= rows[i].cont;
            scurve_select     <= rows[i].ssel;
            @(posedge clk);
            #1;
            check("scurve_enable", decel_ctl.scurve_enable, rows[i].sc);
            check("auto_decel_enable", decel_ctl.auto_decel_enable, rows[i].ad);
        end
        // Tagged segment: point 3, so the fourth pulse is the first one past it
        strobe(0);
        strobe(1);
        repeat (3) strobe(2);
        watch(2);
        check("decel_start early", decel_ctl.decel_start, 1'b0);
        strobe(2);
        watch(2);
        check("decel_start late", decel_ctl.decel_start, 1'b1);
        strobe(3);
        watch(1);
        check("decel_start cleared", decel_ctl.decel_start, 1'b0);
        // Single-step: arming alone must stay silent
        cmd(IASS_CMD_MODE, 16'h0200);
        check("sstep_mode", sstep_mode, 1'b1);
        strobe(0);
        watch(6);
        check("armed silent", seen_p, 4'h0);
        @(posedge clk);
        host_cmd <= '{valid: 1'b1, code: IASS_CMD_STEP, data: 16'h0000};
        #1;
        check("step_req", step_req, 1'b1);
        @(posedge clk);
        host_cmd <= '0;
        #1;
        check("axis_pulse step", axis_pulse, step_axes);
        n = 0;
        while (axis_pulse !== 4'h0 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("high width", n, main_pulse_period >> 1);
        watch(6);
        check("low persists", seen_p, 4'h0);
        // Two external low pulses, each gives exactly one step
        for (int k = 0; k < 2; k++) begin
            strobe(4);
            n = 0;
            while (axis_pulse === 4'h0 && n < 20) begin
                @(posedge clk);
                #1;
                n++;
            end
            check("ext latency", (n >= IASS_EXT_LAT_MIN) && (n <= IASS_EXT_LAT_MAX), 1'b1);
            check("ext pulse", axis_pulse, step_axes);
            watch(4);
            watch(12);
            check("one step per low", seen_p, 4'h0);
        end
        // Abort: instant stop, wait over a period, then one more step
        cmd(IASS_CMD_INSTOP, 16'h0000);
        watch(12);
        cmd(IASS_CMD_STEP, 16'h0000);
        seen_s = drive_stop;
        seen_p = axis_pulse;
        n = int'(seen_s);
        watch(3);
        check("abort stop", n | int'(seen_s), 1);
        check("abort no pulse", seen_p, 4'h0);
        cmd(IASS_CMD_STEP, 16'h0000);
        watch(8);
        check("step after finish", seen_p, 4'h0);
        strobe(4);
        watch(12);
        check("ext after finish", seen_p, 4'h0);
        // Mid-run reset drops every enable
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("decel_enabled mid reset", decel_enabled, IASS_DECEL_EN_RST);
        check("sstep_mode mid reset", sstep_mode, IASS_SSTEP_RST);
        @(posedge clk);
        sys_rst <= 1'b0;
        // Automatic request only counts once deceleration is enabled
        strobe(5);
        watch(1);
        check("auto decel while disabled", decel_ctl.decel_start, 1'b0);
        cmd(IASS_CMD_DECEL_ON, 16'h0000);
        strobe(5);
        watch(1);
        check("auto decel", decel_ctl.decel_start, 1'b1);
        strobe(3);
        // Finish arriving during the last high phase still ends the drive
        cmd(IASS_CMD_MODE, 16'h0200);
        strobe(0);
        cmd(IASS_CMD_STEP, 16'h0000);
        check("last pulse", axis_pulse, step_axes);
        strobe(3);
        watch(12);
        cmd(IASS_CMD_STEP, 16'h0000);
        watch(8);
        check("step after last pulse", seen_p, 4'h0);
        end_of_test();
    end
endmodule : iass_top_bench
